// [logic/mma_core.sv]
// Program counter, return stack, data address and wake logic
`default_nettype none
module mma_core
  import mma_pkg::*;
#(
  parameter int PCW   = PC_W,
  parameter int DEPTH = STK_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Program flow request from the core
  input  wire mma_op_t          op_i,
  input  wire logic [PCW-1:0]   target_i,
  input  wire logic [PCW-1:0]   pc_load_i,
  input  wire logic             pc_load_en_i,
  // Data addressing
  input  wire mma_page_t        page_i,
  input  wire logic [7:0]       status_i,
  input  wire logic [7:0]       indirect_pointer_reg_i,
  input  wire logic [6:0]       opcode_loc_i,
  // Power state and wake events
  input  wire mma_pwr_t         pwr_i,
  input  wire logic [10:0]      events_i,
  // Outputs
  output logic [PCW-1:0]        pc_o,
  output logic [DADDR_W-1:0]    data_addr_o,
  output logic                  is_sfr_o,
  output logic                  ram_present_o,
  output logic                  rsvd_fetch_o,
  output logic                  wake_o
);
  // Pointer width; the wrap below relies on DEPTH being a power of two
  localparam int SPW = $clog2(DEPTH);

  // Program counter and stack pointer
  logic [PCW-1:0] pc;
  logic [PCW-1:0] next_pc;
  logic [SPW-1:0] sp;
  logic [SPW-1:0] next_sp;

  // Return addresses, one word per nesting level
  logic [PCW-1:0] stack      [DEPTH];
  logic [PCW-1:0] next_stack [DEPTH];

  // Decoded program flow request
  logic           push;
  logic           pop;
  logic [PCW-1:0] seq_pc;
  logic [PCW-1:0] page_pc;
  logic [PCW-1:0] flow_pc;
  logic [PCW-1:0] top;
  logic [SPW-1:0] top_idx;

  // Data addressing
  logic [1:0]         bank;
  logic [6:0]         loc;
  logic [1:0]         phys_bank;
  logic               indirect;
  logic               alt_page;
  logic               special_function_regs;
  logic               ram;
  logic [DADDR_W-1:0] next_data_addr;
  logic               next_is_sfr;
  logic               next_ram_present;

  // Wake decision
  logic [10:0] armed_events;
  logic        next_wake;

  // Address of the following instruction, wraps at the top of program space
  assign seq_pc  = pc + PCW'(1);
  // Short targets stay inside the current 256-word page
  assign page_pc = {pc[PCW-1:8], target_i[7:0]};
  // Newest entry sits one below the write pointer
  assign top_idx = sp - SPW'(1);
  assign top     = stack[top_idx];

  always_comb begin
    flow_pc = seq_pc;
    push    = 1'b0;
    pop     = 1'b0;
    case (op_i)
      MMA_NEXT: begin
        flow_pc = seq_pc;
      end
      MMA_SHORT: begin
        flow_pc = page_pc;
      end
      MMA_FAR: begin
        flow_pc = target_i;
      end
      MMA_CALLS: begin
        flow_pc = page_pc;
        push    = 1'b1;
      end
      MMA_CALLF: begin
        flow_pc = target_i;
        push    = 1'b1;
      end
      MMA_RET: begin
        flow_pc = top;
        pop     = 1'b1;
      end
      MMA_SWI: begin
        flow_pc = SWI_VEC[PCW-1:0];
        push    = 1'b1;
      end
      MMA_HWI: begin
        flow_pc = HWI_VEC[PCW-1:0];
        push    = 1'b1;
      end
      default: begin
        flow_pc = seq_pc;
      end
    endcase
  end

  always_comb begin
    next_pc    = flow_pc;
    next_sp    = sp;
    next_stack = stack;
    // A direct counter write replaces the target; the stack still moves
    if (pc_load_en_i) begin
      next_pc = pc_load_i;
    end
    if (push) begin
      next_stack[sp] = seq_pc;
      // No overflow flag: a ninth push overwrites the oldest entry
      next_sp = sp + SPW'(1);
    end else if (pop) begin
      next_sp = top_idx;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= RESET_VEC[PCW-1:0];
      sp <= '0;
    end else if (ce_i) begin
      pc <= next_pc;
      sp <= next_sp;
    end
  end

  // Stack words carry no reset; a pop of an empty stack returns stale data
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      stack <= next_stack;
    end
  end

  assign pc_o         = pc;
  assign rsvd_fetch_o = (pc >= PC_RSVD_LO[PCW-1:0]);

  always_comb begin
    alt_page = (page_i != MMA_PAGE_R);
    indirect = !alt_page && (opcode_loc_i == INDIR_LOC);
    bank     = status_i[BANK_HI:BANK_LO];
    loc      = opcode_loc_i;
    if (indirect) begin
      loc = indirect_pointer_reg_i[6:0];
    end
    if (alt_page) begin
      bank = 2'h0;
    end
    // Special registers exist once, in bank zero
    special_function_regs       = (loc <= SFR_LAST);
    ram       = !alt_page && !special_function_regs;
    phys_bank = 2'h0;
    // Banks one and three share the bank one RAM below 0x40
    if (ram && bank[0] && loc <= B1_RAM_LAST) begin
      phys_bank = 2'h1;
    end
    next_data_addr   = {phys_bank, loc};
    next_is_sfr      = special_function_regs;
    next_ram_present = ram;
  end

  always_comb begin
    armed_events = '0;
    case (pwr_i)
      MMA_STANDBY: begin
        armed_events = events_i;
      end
      MMA_HALT: begin
        armed_events = events_i & HALT_WAKE_MASK;
      end
      default: begin
        armed_events = '0;
      end
    endcase
    // Level only: the event source must hold its request until serviced
    next_wake = |armed_events;
  end

  // Registered address and wake for the data path
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_addr_o   <= '0;
      is_sfr_o      <= 1'b0;
      ram_present_o <= 1'b0;
      wake_o        <= 1'b0;
    end else if (ce_i) begin
      data_addr_o   <= next_data_addr;
      is_sfr_o      <= next_is_sfr;
      ram_present_o <= next_ram_present;
      wake_o        <= next_wake;
    end
  end
endmodule : mma_core
`default_nettype wire

// [logic/mma_pkg.sv]
// Constants shared by the memory addressing block
// What this block does
// - Program counter is eleven bits wide, covering the whole 2K-word program space.
// - Reset loads the program counter with address zero and fetching starts there.
// - A software interrupt sends execution to program address one.
// - Every accepted hardware interrupt goes to the shared vector at address eight unless a direct counter write comes in the same cycle.
// - Short jumps and calls reach 256 locations; far ones reach any address.
// - Calls and interrupts push the next address; a return pops it into PC unless a direct counter write comes in the same cycle.
// - The return stack holds eight levels of nested calls and interrupts.
// - Addresses 0x00E and 0x00F are fetched like any other program word.
// - Data memory has four banks, picked by status register bits seven and six.
// - Indirect access uses the status bank and pointer register bits six to zero.
// - Direct access uses the status bank and the opcode's seven low bits.
// - Special registers sit at 0x0 to 0x1F of bank zero, reachable normally.
// - Special registers alias to bank zero; RAM exists only in banks zero and one.
// - Alternate page accesses ignore the bank-select bits.
// - Standby wakes on any of the eleven interrupt events.
// - Halt wakes only on watchdog, port change or either external interrupt.
`default_nettype none
package mma_pkg;
  localparam int          PC_W        = 11;
  localparam int          STK_DEPTH   = 8;
  localparam int          DADDR_W     = 9;
  localparam logic [10:0] RESET_VEC   = 11'h000;
  localparam logic [10:0] SWI_VEC     = 11'h001;
  localparam logic [10:0] HWI_VEC     = 11'h008;
  localparam logic [10:0] PC_RSVD_LO  = 11'h7FE;
  localparam int          BANK_HI     = 7;
  localparam int          BANK_LO     = 6;
  localparam logic [6:0]  SFR_LAST    = 7'h1F;
  localparam logic [6:0]  B1_RAM_LAST = 7'h3F;
  localparam logic [6:0]  INDIR_LOC   = 7'h00;
  localparam int          NUM_EVENTS  = 11;
  // Event bit positions
  localparam int EV_T0 = 0;
  localparam int EV_T1 = 1;
  localparam int EV_T2 = 2;
  localparam int EV_T3 = 3;
  localparam int EV_WDT = 4;
  localparam int EV_PORT = 5;
  localparam int EV_EXT0 = 6;
  localparam int EV_EXT1 = 7;
  localparam int EV_LVD = 8;
  localparam int EV_CMP = 9;
  localparam int EV_ADC = 10;
  localparam logic [10:0] HALT_WAKE_MASK = 11'h0F0;

  typedef enum logic [2:0] {
    MMA_NEXT  = 3'b000,
    MMA_SHORT = 3'b001,
    MMA_FAR   = 3'b011,
    MMA_CALLS = 3'b010,
    MMA_CALLF = 3'b110,
    MMA_RET   = 3'b111,
    MMA_SWI   = 3'b101,
    MMA_HWI   = 3'b100
  } mma_op_t;

  typedef enum logic [1:0] {
    MMA_RUN     = 2'b00,
    MMA_STANDBY = 2'b01,
    MMA_HALT    = 2'b11
  } mma_pwr_t;

  typedef enum logic [1:0] {
    MMA_PAGE_R = 2'b00,
    MMA_PAGE_F = 2'b01,
    MMA_PAGE_S = 2'b10
  } mma_page_t;
endpackage : mma_pkg
`default_nettype wire

// [verification/mma_core_chk.sv]
// Port assertions for the memory addressing block
`default_nettype none
module mma_core_chk
  import mma_pkg::*;
#(parameter int PCW = PC_W) (
  input wire logic clk_i, rst_i, ce_i, pc_load_en_i, wake_o, is_sfr_o,
  input wire logic ram_present_o,
  input wire mma_op_t op_i,
  input wire mma_page_t page_i,
  input wire mma_pwr_t pwr_i,
  input wire logic [PCW-1:0] target_i, pc_o,
  input wire logic [10:0] events_i,
  input wire logic [7:0] status_i,
  input wire logic [6:0] opcode_loc_i,
  input wire logic [8:0] data_addr_o
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic go = ce_i && !pc_load_en_i;
  wire logic rp = go && page_i == MMA_PAGE_R;
  sequence s_op(mma_op_t o); go && op_i == o; endsequence
  sequence s_cr; s_op(MMA_CALLF) ##1 s_op(MMA_RET); endsequence
  a_swi_vec: assert property (s_op(MMA_SWI) |=> pc_o == SWI_VEC)
    else $error("soft interrupt vector wrong");
  a_hwi_vec: assert property (s_op(MMA_HWI) |=> pc_o == HWI_VEC)
    else $error("hard interrupt vector wrong");
  a_short_page: assert property (s_op(MMA_SHORT) |=> pc_o ==
    ($past(pc_o) & 11'h700 | $past(target_i) & 11'h0FF)) else $error("short");
  a_call_ret: assert property (s_cr |=> pc_o == $past(pc_o, 2) + 11'h001)
    else $error("return address wrong");
  a_direct_bank: assert property (rp && status_i[7:6] == 2'h0 &&
    opcode_loc_i != 7'h00 |=> data_addr_o == {2'h0, $past(opcode_loc_i)})
    else $error("direct address wrong");
  a_sfr_alias: assert property (rp && opcode_loc_i inside {[7'h01:7'h1F]}
    |=> is_sfr_o && data_addr_o[8:7] == 2'h0) else $error("sfr alias");
  a_alt_page: assert property (go && page_i != MMA_PAGE_R
    |=> data_addr_o[8:7] == 2'h0 && !ram_present_o) else $error("alt page");
  a_halt_wake: assert property (go && pwr_i == MMA_HALT
    |=> wake_o == |($past(events_i) & HALT_WAKE_MASK)) else $error("halt");
endmodule // mma_core_chk
bind mma_core mma_core_chk #(.PCW(PCW)) i_mma_core_chk (.clk_i, .rst_i,
  .ce_i, .pc_load_en_i, .wake_o, .is_sfr_o, .ram_present_o, .op_i, .page_i,
  .pwr_i, .target_i, .pc_o, .events_i, .status_i, .opcode_loc_i, .data_addr_o);
`default_nettype wire

// [verification/mma_core_tb.sv]
// Self-checking bench for the memory addressing block
`default_nettype none
module mma_core_tb
  import mma_pkg::*;
;
  timeunit 1ns / 1ns;
  logic clk_i = 0, rst_i = 1, wake_o, is_sfr_o, ram_o, rsvd_o;
  logic [1:0] bank = 2'h0;
  logic [7:0] stat, indirect_pointer_reg = 8'hB0;
  logic [6:0] loc = 7'h00;
  logic [10:0] tgt = 11'h000, ev = 11'h000, pc_o;
  logic [8:0] data_addr_o;
  logic ce = 1'b1, pld = 1'b0;
  logic [10:0] pl = 11'h000;
  mma_op_t op = MMA_NEXT;
  mma_page_t pg = MMA_PAGE_R;
  mma_pwr_t pw = MMA_RUN;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  mma_partner i_mma_partner (.bank_i(bank), .status_o(stat));
  mma_core i_mma_core (.clk_i, .rst_i, .ce_i(ce), .op_i(op), .target_i(tgt),
    .pc_load_i(pl), .pc_load_en_i(pld), .page_i(pg), .status_i(stat),
    .indirect_pointer_reg_i(indirect_pointer_reg), .opcode_loc_i(loc), .pwr_i(pw),
    .events_i(ev), .pc_o, .data_addr_o, .is_sfr_o, .ram_present_o(ram_o),
    .rsvd_fetch_o(rsvd_o), .wake_o);
  task automatic cmp(input logic [10:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic go(input mma_op_t o, input logic [10:0] t, e);
    op = o;
    tgt = t;
    @(negedge clk_i);
    cmp(pc_o, e);
  endtask
  task automatic dm(input mma_page_t p, input logic [1:0] b,
                    input logic [6:0] l, input logic [8:0] e,
                    input logic [1:0] f);
    pg = p;
    bank = b;
    loc = l;
    @(negedge clk_i);
    cmp(11'(data_addr_o), 11'(e));
    cmp(11'({is_sfr_o, ram_o}), 11'(f));
  endtask
  task automatic t_flow;
    cmp(pc_o, RESET_VEC);
    go(MMA_CALLF, 11'h123, 11'h123);
    go(MMA_SWI, 11'h000, SWI_VEC);
    go(MMA_HWI, 11'h000, HWI_VEC);
    go(MMA_RET, 11'h000, 11'h002);
    go(MMA_RET, 11'h000, 11'h124);
    go(MMA_SHORT, 11'h7AB, 11'h1AB);
    go(MMA_RET, 11'h000, 11'h001);
    go(MMA_FAR, 11'h00E, 11'h00E);
    go(MMA_NEXT, 11'h000, 11'h00F);
  endtask
  task automatic t_stack;
    for (logic [10:0] a = 11'h100; a < 11'h109; a++) go(MMA_CALLF, a, a);
    for (logic [10:0] a = 11'h108; a > 11'h100; a--) go(MMA_RET, 11'h000, a);
    go(MMA_RET, 11'h000, 11'h108);
    op = MMA_NEXT;
  endtask
  task automatic t_data;
    dm(MMA_PAGE_R, 2'h0, 7'h7F, 9'h07F, 2'h1);
    dm(MMA_PAGE_R, 2'h1, 7'h25, 9'h0A5, 2'h1);
    dm(MMA_PAGE_R, 2'h1, 7'h45, 9'h045, 2'h1);
    dm(MMA_PAGE_R, 2'h2, 7'h25, 9'h025, 2'h1);
    dm(MMA_PAGE_R, 2'h3, 7'h25, 9'h0A5, 2'h1);
    dm(MMA_PAGE_R, 2'h3, 7'h05, 9'h005, 2'h2);
    dm(MMA_PAGE_R, 2'h1, 7'h00, 9'h0B0, 2'h1);
    dm(MMA_PAGE_F, 2'h3, 7'h25, 9'h025, 2'h0);
    dm(MMA_PAGE_S, 2'h1, 7'h45, 9'h045, 2'h0);
  endtask
  task automatic t_hold;
    go(MMA_FAR, 11'h7FE, 11'h7FE);
    cmp(11'(rsvd_o), 11'h001);
    ce = 1'b0;
    go(MMA_FAR, 11'h055, 11'h7FE);
    ce = 1'b1;
    go(MMA_NEXT, 11'h000, 11'h7FF);
    cmp(11'(rsvd_o), 11'h001);
    pl = 11'h3C0;
    pld = 1'b1;
    go(MMA_FAR, 11'h055, 11'h3C0);
    pld = 1'b0;
    cmp(11'(rsvd_o), 11'h000);
  endtask
  task automatic t_reset;
    op = MMA_FAR;
    tgt = 11'h2AA;
    rst_i = 1'b1;
    @(negedge clk_i);
    cmp(pc_o, RESET_VEC);
    cmp(11'(data_addr_o), 11'h000);
    rst_i = 1'b0;
    go(MMA_FAR, 11'h2AA, 11'h2AA);
    go(MMA_NEXT, 11'h000, 11'h2AB);
  endtask
  task automatic t_wake;
    ev = 11'h7FF;
    pw = MMA_RUN;
    @(negedge clk_i);
    cmp(11'(wake_o), 11'h000);
    ev = 11'h000;
    pw = MMA_STANDBY;
    @(negedge clk_i);
    cmp(11'(wake_o), 11'h000);
    for (int i = 0; i < NUM_EVENTS; i++) begin
      ev = 11'h001 << i;
      pw = MMA_STANDBY;
      @(negedge clk_i);
      cmp(11'(wake_o), 11'h001);
      pw = MMA_HALT;
      @(negedge clk_i);
      cmp(11'(wake_o), 11'(i >= EV_WDT && i <= EV_EXT1));
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 400) begin
      n_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    t_flow;
    t_stack;
    t_data;
    t_hold;
    t_wake;
    t_reset;
    end_of_test;
  end
endmodule // mma_core_tb
`default_nettype wire

// [verification/mma_partner.sv]
// Core-side model: status register that carries the bank bits
`default_nettype none
module mma_partner (
  input  wire logic [1:0] bank_i,
  output var  logic [7:0] status_o
);
  timeunit 1ns / 1ns;
  // Low bits busy so only the bank field may steer the address
  assign status_o = {bank_i, 6'h15};
endmodule // mma_partner
`default_nettype wire
